// ---- logic/ducp_pkg.sv ----
package ducp_pkg;

  // User command codes on the three-bit command input
  localparam logic [2:0] CMD_NOP   = 3'h0;  // Nothing to do
  localparam logic [2:0] CMD_INIT  = 3'h2;  // Start memory initialization
  localparam logic [2:0] CMD_WRITE = 3'h4;  // Write request
  localparam logic [2:0] CMD_READ  = 3'h6;  // Read request

  // Clock rate and timing figures
  localparam int CLK_MHZ         = 200;    // Main clock, 5 ns period
  localparam int INIT_TIME_US    = 200;    // Power-up wait before memory is usable
  localparam int INIT_CYCLES     = INIT_TIME_US * CLK_MHZ;
  localparam int PRECH_TIME_NS   = 15;     // Row close time after a transfer
  localparam int PRECH_CYCLES    = (PRECH_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_TAIL_CYCLES  = 8;      // Wait for read beats still in flight
  localparam int TIMER_W         = 16;     // Width of the shared wait timer

  // Terminate hold lengths, in clock cycles, per burst length
  localparam logic [2:0] TERM_BL4 = 3'h2;
  localparam logic [2:0] TERM_BL8 = 3'h4;

  // Columns covered by one double-width user word (two memory beats)
  localparam int COL_STEP = 2;

  // Reset values
  localparam logic RST_LOW  = 1'b0;
  localparam logic RST_HIGH = 1'b1;

  // Controller states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_INIT   = 7'h02,
    ST_WRITE  = 7'h04,
    ST_WDRAIN = 7'h08,
    ST_READ   = 7'h10,
    ST_RDRAIN = 7'h20,
    ST_PRECH  = 7'h40
  } ducp_state_type;

endpackage

// ---- logic/ducp_stream_if.sv ----
`timescale 1ns/10ps
// Valid/ready word stream between the port logic and its write buffer
interface ducp_stream_if #(
  parameter int W = 8
);
  logic         valid;  // Word on data is offered
  logic         ready;  // Receiver takes the word this cycle
  logic [W-1:0] data;   // Payload

  // Sending end
  modport src (
    output valid,
    output data,
    input  ready
  );

  // Receiving end
  modport snk (
    input  valid,
    input  data,
    output ready
  );
endinterface

// ---- logic/ducp_fifo.sv ----
`timescale 1ns/10ps
module ducp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // Clock and synchronised reset
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  // Filling side
  ducp_stream_if.snk in_s,
  // Draining side
  ducp_stream_if.src out_s
);
  import ducp_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  arr_q [DEPTH];  // Storage array
  logic [AW-1:0] wp_q, wp_d;     // Write pointer
  logic [AW-1:0] rp_q, rp_d;     // Read pointer
  logic [CW-1:0] cnt_q, cnt_d;   // Words held in the array
  logic          ovld_q, ovld_d; // Output register holds a word
  logic [W-1:0]  odat_q, odat_d; // Output register, so read data leave a flop
  logic          irdy_q, irdy_d; // Registered ready toward the source
  logic          push, load;

  assign in_s.ready = irdy_q;
  assign out_s.valid = ovld_q;
  assign out_s.data = odat_q;

  // Next pointers, count and output stage
  always_comb
  begin
    push   = in_s.valid && irdy_q;
    // Refill the output register when it empties or is being taken
    load   = (cnt_q != '0) && (!ovld_q || out_s.ready);
    wp_d   = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d   = load ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d  = CW'(cnt_q + CW'(push) - CW'(load));
    ovld_d = load ? 1'b1 : (out_s.ready ? 1'b0 : ovld_q);
    odat_d = load ? arr_q[rp_q] : odat_q;
    // Ready from the next count so a full array never takes a word
    irdy_d = (cnt_d != FULL);
  end

  // Register control state
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      ovld_q <= RST_LOW;
      odat_q <= '0;
      irdy_q <= RST_LOW;
    end
    else
    begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      ovld_q <= ovld_d;
      odat_q <= odat_d;
      irdy_q <= irdy_d;
    end
  end

  // Storage writes need no reset
  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      arr_q[wp_q] <= in_s.data;
    end
  end

  // Buffer never takes a word while its count says full
  property p_no_overfill;
    @(posedge clock_i) disable iff (!rst_b_i)
      (cnt_q == FULL) |-> !push;
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo took a word while full");

endmodule // ducp_fifo

// ---- logic/ducp_top.sv ----
`timescale 1ns/10ps
module ducp_top
  import ducp_pkg::*;
#(
  parameter int DQ_W        = 16,
  parameter int DM_W        = 2,
  parameter int BANK_W      = 2,
  parameter int COL_W       = 10,
  parameter int ROW_W       = 13,
  parameter int FIFO_DEPTH  = 16,
  parameter int INIT_CYC    = ducp_pkg::INIT_CYCLES
) (
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_b_i,
  // User command port
  input  wire logic [2:0]                user_cmd_code_i,
  input  wire logic [BANK_W+COL_W+ROW_W-1:0] user_bank_col_row_addr_i,
  input  wire logic                      transfer_terminate_i,
  input  wire logic                      burst_len8_i,
  output logic                           cmd_acknowledge_o,
  output logic                           memory_ready_flag_o,
  // User write data
  input  wire logic [2*DQ_W-1:0]         user_write_word_i,
  input  wire logic [2*DM_W-1:0]         user_write_byte_mask_i,
  input  wire logic                      user_write_valid_i,
  output logic                           user_write_ready_o,
  // User read data
  output logic [2*DQ_W-1:0]              user_read_word_o,
  output logic                           read_word_valid_o,
  // Memory side write beats
  output logic [DQ_W-1:0]                mem_wr_beat_o,
  output logic [DM_W-1:0]                mem_wr_mask_o,
  output logic                           mem_wr_en_o,
  output logic                           mem_wr_rise_o,
  // Memory side commands and address
  output logic                           mem_rd_req_o,
  output logic                           mem_precharge_o,
  output logic [BANK_W-1:0]              mem_bank_o,
  output logic [COL_W-1:0]               mem_col_o,
  output logic [ROW_W-1:0]               mem_row_o,
  // Memory side read beats, from pins
  input  wire logic [DQ_W-1:0]           mem_rd_beat_i,
  input  wire logic                      mem_rd_beat_valid_i
);
  import ducp_pkg::*;

  localparam int WW = 2*DQ_W + 2*DM_W;  // Buffered word: data then mask

  // Reset release chain
  logic rst_m_q, rst_n;
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_m_q <= RST_LOW;
      rst_n   <= RST_LOW;
    end
    else
    begin
      rst_m_q <= RST_HIGH;
      rst_n   <= rst_m_q;
    end
  end

  // Read beats come from pins: two flops before any logic looks
  logic [DQ_W-1:0] beat_m_q, beat_s_q;
  logic            bv_m_q, bv_s_q;
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      beat_m_q <= '0;
      beat_s_q <= '0;
      bv_m_q   <= RST_LOW;
      bv_s_q   <= RST_LOW;
    end
    else
    begin
      beat_m_q <= mem_rd_beat_i;
      beat_s_q <= beat_m_q;
      bv_m_q   <= mem_rd_beat_valid_i;
      bv_s_q   <= bv_m_q;
    end
  end

  // Write buffer between user and beat serializer
  ducp_stream_if #(.W(WW)) wr_in ();
  ducp_stream_if #(.W(WW)) wr_out ();
  ducp_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_wbuf (
    .clock_i (clock_i),
    .rst_b_i (rst_n),
    .in_s    (wr_in),
    .out_s   (wr_out)
  );

  // Control state
  ducp_state_type       st_q, st_d;      // Controller state
  logic [TIMER_W-1:0]   tmr_q, tmr_d;    // Shared wait timer
  logic [2:0]           term_q, term_d;  // Consecutive terminate cycles
  logic                 rdy_q, rdy_d;    // Memory ready flag
  logic                 ack_q, ack_d;    // Command acknowledge
  logic                 req_q, req_d;    // Read request pulse
  logic                 pre_q, pre_d;    // Precharge pulse
  logic [BANK_W-1:0]    bank_q, bank_d;
  logic [COL_W-1:0]     col_q, col_d;
  logic [ROW_W-1:0]     row_q, row_d;
  // Serializer state
  logic                 pend_q, pend_d;  // Falling-edge beat still to send
  logic [DQ_W-1:0]      lo_q, lo_d;      // Held falling-edge data
  logic [DM_W-1:0]      lom_q, lom_d;    // Held falling-edge mask
  logic [DQ_W-1:0]      wb_q, wb_d;
  logic [DM_W-1:0]      wm_q, wm_d;
  logic                 we_q, we_d;
  logic                 wr_q, wr_d;
  // Read pairing state
  logic [DQ_W-1:0]      hi_q, hi_d;      // Rising-edge beat waiting for its pair
  logic                 half_q, half_d;
  logic [2*DQ_W-1:0]    rw_q, rw_d;
  logic                 rv_q, rv_d;

  logic                 idle, acc_wr, acc_rd, acc_init, pop, term_done, rd_active;
  logic [2:0]           term_len;
  logic [2*DQ_W-1:0]    pop_data;
  logic [2*DM_W-1:0]    pop_mask;

  assign pop_data = wr_out.data[WW-1 -: 2*DQ_W];
  assign pop_mask = wr_out.data[2*DM_W-1:0];

  // Command decode and next control state
  always_comb
  begin
    idle      = (st_q == ST_IDLE);
    // Reserved codes match none of these and leave the state alone
    acc_init  = idle && (user_cmd_code_i == CMD_INIT);
    acc_wr    = idle && rdy_q && (user_cmd_code_i == CMD_WRITE);
    acc_rd    = idle && rdy_q && (user_cmd_code_i == CMD_READ);
    // Write data taken with the command, then while the transfer runs
    wr_in.valid = acc_wr || ((st_q == ST_WRITE) && user_write_valid_i);
    wr_in.data  = {user_write_word_i, user_write_byte_mask_i};
    term_len  = burst_len8_i ? TERM_BL8 : TERM_BL4;
    term_done = transfer_terminate_i && (term_q == 3'(term_len - 3'h1));
    pop       = wr_out.valid && !pend_q;
    st_d   = st_q;
    tmr_d  = tmr_q;
    term_d = transfer_terminate_i ? 3'(term_q + 3'h1) : 3'h0;
    rdy_d  = rdy_q;
    req_d  = 1'b0;
    pre_d  = 1'b0;
    bank_d = bank_q;
    row_d  = row_q;
    col_d  = col_q;
    // Column moves inside the row only; overflow wraps, row never changes
    if (pop || req_q)
    begin
      col_d = COL_W'(col_q + COL_W'(COL_STEP));
    end
    unique case (st_q)
      ST_IDLE:
      begin
        term_d = 3'h0;
        if (acc_wr || acc_rd)
        begin
          // Bank in low bits, column above, row on top
          bank_d = user_bank_col_row_addr_i[BANK_W-1:0];
          col_d  = user_bank_col_row_addr_i[BANK_W +: COL_W];
          row_d  = user_bank_col_row_addr_i[BANK_W+COL_W +: ROW_W];
          st_d   = acc_wr ? ST_WRITE : ST_READ;
        end
        else if (acc_init && !rdy_q)
        begin
          // Init is taken only while the ready flag is clear; once set, later init codes are ignored
          st_d  = ST_INIT;
          tmr_d = TIMER_W'(INIT_CYC - 1);
        end
      end
      ST_INIT:
      begin
        if (tmr_q == '0)
        begin
          rdy_d = 1'b1;
          st_d  = ST_IDLE;
        end
        else
        begin
          tmr_d = TIMER_W'(tmr_q - 1'b1);
        end
      end
      ST_WRITE:
      begin
        if (term_done)
        begin
          st_d = ST_WDRAIN;
        end
      end
      ST_WDRAIN:
      begin
        // Every buffered word reaches the memory before the row closes, except one pushed into an empty buffer in the terminate cycle
        if (!wr_out.valid && !pend_q)
        begin
          st_d  = ST_PRECH;
          pre_d = 1'b1;
          tmr_d = TIMER_W'(PRECH_CYCLES - 1);
        end
      end
      ST_READ:
      begin
        req_d = !req_q;  // One request per two beats
        if (term_done)
        begin
          req_d = 1'b0;
          st_d  = ST_RDRAIN;
          tmr_d = TIMER_W'(RD_TAIL_CYCLES - 1);
        end
      end
      ST_RDRAIN:
      begin
        if (tmr_q == '0)
        begin
          st_d  = ST_PRECH;
          pre_d = 1'b1;
          tmr_d = TIMER_W'(PRECH_CYCLES - 1);
        end
        else
        begin
          tmr_d = TIMER_W'(tmr_q - 1'b1);
        end
      end
      ST_PRECH:
      begin
        if (tmr_q == '0)
        begin
          st_d = ST_IDLE;
        end
        else
        begin
          tmr_d = TIMER_W'(tmr_q - 1'b1);
        end
      end
      default:
      begin
        st_d = ST_IDLE;  // Illegal one-hot code
      end
    endcase
    // Acknowledge covers the transfer through the end of precharge
    ack_d = !((st_d == ST_IDLE) || (st_d == ST_INIT));
  end

  // Serializer and read pairing, next values
  always_comb
  begin
    wr_out.ready = !pend_q;
    rd_active    = (st_q == ST_READ) || (st_q == ST_RDRAIN);
    pend_d = 1'b0;
    lo_d   = lo_q;
    lom_d  = lom_q;
    wb_d   = wb_q;
    wm_d   = wm_q;
    we_d   = 1'b0;
    wr_d   = 1'b0;
    if (pop)
    begin
      // Upper half first on the rising edge, lower half held for falling
      wb_d   = pop_data[2*DQ_W-1 -: DQ_W];
      wm_d   = pop_mask[2*DM_W-1 -: DM_W];
      lo_d   = pop_data[DQ_W-1:0];
      lom_d  = pop_mask[DM_W-1:0];
      we_d   = 1'b1;
      wr_d   = 1'b1;
      pend_d = 1'b1;
    end
    else if (pend_q)
    begin
      wb_d = lo_q;
      wm_d = lom_q;
      we_d = 1'b1;
    end
    hi_d   = hi_q;
    half_d = rd_active ? half_q : 1'b0;
    rw_d   = rw_q;
    rv_d   = 1'b0;
    if (rd_active && bv_s_q)
    begin
      if (!half_q)
      begin
        hi_d   = beat_s_q;
        half_d = 1'b1;
      end
      else
      begin
        rw_d   = {hi_q, beat_s_q};
        rv_d   = 1'b1;
        half_d = 1'b0;
      end
    end
  end

  // Register all state
  always_ff @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;  tmr_q <= '0;  term_q <= '0;
      rdy_q <= RST_LOW;  ack_q <= RST_LOW;
      req_q <= RST_LOW;  pre_q <= RST_LOW;
      bank_q <= '0;  col_q <= '0;  row_q <= '0;
      pend_q <= RST_LOW;  lo_q <= '0;  lom_q <= '0;
      wb_q <= '0;  wm_q <= '0;  we_q <= RST_LOW;  wr_q <= RST_LOW;
      hi_q <= '0;  half_q <= RST_LOW;  rw_q <= '0;  rv_q <= RST_LOW;
    end
    else
    begin
      st_q <= st_d;  tmr_q <= tmr_d;  term_q <= term_d;
      rdy_q <= rdy_d;  ack_q <= ack_d;
      req_q <= req_d;  pre_q <= pre_d;
      bank_q <= bank_d;  col_q <= col_d;  row_q <= row_d;
      pend_q <= pend_d;  lo_q <= lo_d;  lom_q <= lom_d;
      wb_q <= wb_d;  wm_q <= wm_d;  we_q <= we_d;  wr_q <= wr_d;
      hi_q <= hi_d;  half_q <= half_d;  rw_q <= rw_d;  rv_q <= rv_d;
    end
  end

  // Outputs straight from flops
  assign cmd_acknowledge_o   = ack_q;
  assign memory_ready_flag_o = rdy_q;
  assign user_write_ready_o  = wr_in.ready;
  assign user_read_word_o    = rw_q;
  assign read_word_valid_o   = rv_q;
  assign mem_wr_beat_o       = wb_q;
  assign mem_wr_mask_o       = wm_q;
  assign mem_wr_en_o         = we_q;
  assign mem_wr_rise_o       = wr_q;
  assign mem_rd_req_o        = req_q;
  assign mem_precharge_o     = pre_q;
  assign mem_bank_o          = bank_q;
  assign mem_col_o           = col_q;
  assign mem_row_o           = row_q;

  // Acknowledge rises only after an accepted write or read
  property p_ack_cause;
    @(posedge clock_i) disable iff (!rst_n)
      $rose(ack_q) |-> $past(acc_wr || acc_rd);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack rose without command");

  // Ready flag never falls once set
  property p_ready_sticky;
    @(posedge clock_i) disable iff (!rst_n)
      rdy_q |=> rdy_q;
  endproperty
  a_ready_sticky: assert property (p_ready_sticky) else $error("ready flag dropped");

  // Reserved code in idle leaves the controller idle
  property p_reserved_nop;
    @(posedge clock_i) disable iff (!rst_n)
      (idle && user_cmd_code_i[0]) |=> (st_q == ST_IDLE) && !ack_q;
  endproperty
  a_reserved_nop: assert property (p_reserved_nop) else $error("reserved code acted on");

  // Popped word goes out upper half then lower half
  property p_beat_order;
    logic [2*DQ_W-1:0] w;
    @(posedge clock_i) disable iff (!rst_n)
      (pop, w = pop_data) |=> (we_q && wr_q && wb_q == w[2*DQ_W-1 -: DQ_W])
        ##1 (we_q && !wr_q && wb_q == w[DQ_W-1:0]);
  endproperty
  a_beat_order: assert property (p_beat_order) else $error("beat order wrong");

  // Mask halves follow their data halves
  property p_mask_order;
    logic [2*DM_W-1:0] m;
    @(posedge clock_i) disable iff (!rst_n)
      (pop, m = pop_mask) |=> (wm_q == m[2*DM_W-1 -: DM_W]) ##1 (wm_q == m[DM_W-1:0]);
  endproperty
  a_mask_order: assert property (p_mask_order) else $error("mask order wrong");

  // Address fields land in bank, column and row
  property p_addr_split;
    @(posedge clock_i) disable iff (!rst_n)
      (acc_wr || acc_rd) |=> {row_q, col_q, bank_q} == $past(user_bank_col_row_addr_i);
  endproperty
  a_addr_split: assert property (p_addr_split) else $error("address split wrong");

  // Write command pushes its data in the same cycle
  property p_data_with_cmd;
    @(posedge clock_i) disable iff (!rst_n)
      acc_wr |-> wr_in.valid && wr_in.ready;
  endproperty
  a_data_with_cmd: assert property (p_data_with_cmd) else $error("write data not taken");

  // Terminate held for its full length ends the write phase
  property p_term_ends;
    @(posedge clock_i) disable iff (!rst_n)
      ((st_q == ST_WRITE) && term_done) |=> (st_q == ST_WDRAIN) ##1 !wr_in.valid;
  endproperty
  a_term_ends: assert property (p_term_ends) else $error("terminate ignored");

  // Row stays put for the whole transfer
  property p_one_row;
    @(posedge clock_i) disable iff (!rst_n)
      (ack_q && $past(ack_q)) |-> $stable(row_q) && $stable(bank_q);
  endproperty
  a_one_row: assert property (p_one_row) else $error("row changed mid transfer");

  // Read word is the paired beats, flagged for one cycle
  property p_read_pair;
    @(posedge clock_i) disable iff (!rst_n)
      (rd_active && bv_s_q && half_q)
        |=> rv_q && (rw_q == {$past(hi_q), $past(beat_s_q)}) ##1 !rv_q;
  endproperty
  a_read_pair: assert property (p_read_pair) else $error("read pairing wrong");

endmodule // ducp_top

// ---- testbench/ducp_mem_model.sv ----
`timescale 1ns/10ps
// Memory-side read model: answers each read request with two beats
module ducp_mem_model (
  // Clock
  input  wire logic        clock_i,
  // Requests from the port
  input  wire logic        rd_req_i,
  input  wire logic [9:0]  col_i,
  // Beats back toward the port
  output logic [15:0]      beat_o,
  output logic             beat_valid_o
);
  logic [15:0] pend_q[$];        // Beats still owed to the port
  logic [15:0] beat_q  = 16'h0;  // Beat lines as driven
  logic        valid_q = 1'b0;   // Beat valid as driven

  // One process owns the lines; the ports only follow it
  assign beat_o       = beat_q;
  assign beat_valid_o = valid_q;

  // Queue a tagged beat pair per request, send one beat per cycle.
  // Between beats the data lines flip so a stale value is never read as good.
  always @(posedge clock_i)
  begin
    if (rd_req_i)
    begin
      pend_q.push_back({6'h2a, col_i});
      pend_q.push_back(~{6'h2a, col_i});
    end
    if (pend_q.size() > 0)
    begin
      beat_q  <= pend_q.pop_front();
      valid_q <= 1'b1;
    end
    else
    begin
      beat_q  <= ~beat_q;
      valid_q <= 1'b0;
    end
  end
endmodule // ducp_mem_model

// ---- testbench/tb_ducp_top.sv ----
`timescale 1ns/10ps
module tb_ducp_top;
  import ducp_pkg::*;

  logic        clock_i = 1'b0;          // 200 MHz main clock
  logic        rst_b_i = 1'b0;          // Active-low reset
  logic [2:0]  cmd     = CMD_NOP;       // Command code
  logic [24:0] addr    = 25'h0;         // {row, col, bank}
  logic        term    = 1'b0;          // Transfer terminate
  logic        bl8     = 1'b0;          // Burst length eight
  logic [31:0] wword   = 32'h0;         // Write word
  logic [3:0]  wmask   = 4'h0;          // Write mask
  logic        wvalid  = 1'b0;          // Write word offered
  logic        ack, rdy, wready, rvalid, wen, wrise, rreq, prech, bvalid;
  logic [31:0] rword;
  logic [15:0] wbeat, bbeat;
  logic [1:0]  wm, bank;
  logic [9:0]  col;
  logic [12:0] row;
  logic [18:0] beats_q[$];              // Seen write beats {rise, mask, data}
  logic [15:0] rd_tag;                  // Expected upper half of a read word
  int          num_errors = 0;
  int          n_tests    = 0;
  int          n_req = 0, n_word = 0, n_prech = 0;

  always #2.5 clock_i = ~clock_i;

  ducp_top #(.INIT_CYC(10)) ducp_top_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .user_cmd_code_i(cmd),
    .user_bank_col_row_addr_i(addr), .transfer_terminate_i(term), .burst_len8_i(bl8),
    .cmd_acknowledge_o(ack), .memory_ready_flag_o(rdy), .user_write_word_i(wword),
    .user_write_byte_mask_i(wmask), .user_write_valid_i(wvalid),
    .user_write_ready_o(wready), .user_read_word_o(rword), .read_word_valid_o(rvalid),
    .mem_wr_beat_o(wbeat), .mem_wr_mask_o(wm), .mem_wr_en_o(wen), .mem_wr_rise_o(wrise),
    .mem_rd_req_o(rreq), .mem_precharge_o(prech), .mem_bank_o(bank), .mem_col_o(col),
    .mem_row_o(row), .mem_rd_beat_i(bbeat), .mem_rd_beat_valid_i(bvalid));

  ducp_mem_model ducp_mem_model_inst (
    .clock_i(clock_i), .rd_req_i(rreq), .col_i(col), .beat_o(bbeat),
    .beat_valid_o(bvalid));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Monitor at the falling edge, where registered outputs have settled.
  // Read words must carry the column of their request, two columns apart.
  always @(negedge clock_i)
  begin
    if (wen)
      beats_q.push_back({wrise, wm, wbeat});
    if (rreq)
      n_req++;
    if (prech)
      n_prech++;
    if (rvalid)
    begin
      rd_tag = {6'h2a, 10'(10'h10 + 2 * n_word)};
      n_word++;
      check("read upper half", {16'h0, rword[31:16]}, {16'h0, rd_tag});
      check("read lower half", {16'h0, rword[15:0]}, {16'h0, ~rd_tag});
    end
  end

  // Wait, bounded, for the acknowledge to reach a level
  task automatic wait_ack(input logic lvl);
    int n;
    n = 0;
    while (ack !== lvl && n < 300)
    begin
      @(negedge clock_i);
      n++;
    end
    check("ack level", {31'h0, ack}, {31'h0, lvl});
  endtask

  // Hold one code for a cycle, then watch that no transfer starts
  task automatic refused(input logic [2:0] code);
    @(negedge clock_i);
    cmd = code;
    @(negedge clock_i);
    cmd = CMD_NOP;
    repeat (4) @(negedge clock_i);
    check("ack after refused code", {31'h0, ack}, 32'h0);
  endtask

  // Write before init is ignored; init brings up the ready flag to stay
  task automatic test_init;
    refused(CMD_WRITE);
    check("ready before init", {31'h0, rdy}, 32'h0);
    @(negedge clock_i);
    cmd = CMD_INIT;
    @(negedge clock_i);
    cmd = CMD_NOP;
    repeat (12) @(negedge clock_i);
    check("ready after init", {31'h0, rdy}, 32'h1);
    for (int c = 1; c < 8; c += 2)
      refused(c[2:0]);
  endtask

  // Forty words, first with the command; the drain runs at half the fill rate,
  // so the buffer fills and ready must drop. Terminate two cycles at length four.
  task automatic test_write;
    logic [31:0] w;
    logic [3:0]  m;
    int          stalls;
    stalls = 0;
    beats_q.delete();
    n_prech = 0;
    @(negedge clock_i);
    check("write ready when idle", {31'h0, wready}, 32'h1);
    cmd   = CMD_WRITE;
    addr  = {13'h5, 10'h4, 2'h1};
    wword = {8'h00, 8'ha5, 8'hff, 8'h5a};
    wmask = 4'h0;
    @(negedge clock_i);
    cmd = CMD_NOP;
    check("ack after write", {31'h0, ack}, 32'h1);
    check("bank", {30'h0, bank}, 32'h1);
    check("row", {19'h0, row}, 32'h5);
    check("column", {22'h0, col}, 32'h4);
    for (int i = 1; i < 40; i++)
    begin
      wvalid = 1'b1;
      wword  = {i[7:0], 8'ha5, ~i[7:0], 8'h5a};
      wmask  = i[3:0];
      while (wready !== 1'b1)
      begin
        stalls++;
        @(negedge clock_i);
      end
      @(negedge clock_i);
    end
    wvalid = 1'b0;
    term   = 1'b1;
    repeat (2) @(negedge clock_i);
    term = 1'b0;
    wait_ack(1'b0);
    check("buffer pushed back", {31'h0, stalls > 0}, 32'h1);
    check("precharge count", n_prech, 1);
    check("beat count", beats_q.size(), 80);
    for (int i = 0; i < 40 && beats_q.size() == 80; i++)
    begin
      w = {i[7:0], 8'ha5, ~i[7:0], 8'h5a};
      m = i[3:0];
      check("rise beat", {13'h0, beats_q[2*i]}, {13'h0, 1'b1, m[3:2], w[31:16]});
      check("fall beat", {13'h0, beats_q[2*i+1]}, {13'h0, 1'b0, m[1:0], w[15:0]});
    end
  endtask

  // Read at burst length eight, terminated by four cycles
  task automatic test_read;
    n_req   = 0;
    n_word  = 0;
    n_prech = 0;
    bl8     = 1'b1;
    @(negedge clock_i);
    cmd  = CMD_READ;
    // Same row as the write, so no new initialization is owed
    addr = {13'h5, 10'h10, 2'h2};
    @(negedge clock_i);
    cmd = CMD_NOP;
    repeat (6) @(negedge clock_i);
    term = 1'b1;
    repeat (4) @(negedge clock_i);
    term = 1'b0;
    wait_ack(1'b0);
    check("read words vs requests", n_word, n_req);
    check("some read words", {31'h0, n_word > 0}, 32'h1);
    check("read precharge count", n_prech, 1);
    check("ready stays", {31'h0, rdy}, 32'h1);
  endtask

  // Watchdog: the whole run needs well under 3000 cycles
  initial
  begin
    #(5 * 3000);
    num_errors++;
    test_done();
  end

  initial
  begin
    repeat (2) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clock_i);
    test_init();
    test_write();
    test_read();
    test_done();
  end
endmodule // tb_ducp_top
